// [rtl/lsf_pkg.sv]
/*
  Constants for the latched status flag bank: byte offsets, bit positions,
  reset values and supporting constants.
  Assumes a single module clock and a host read port decoded elsewhere.
*/
// Overview of operation
// - Flag field occupies management bytes 3 to 21
// - Flags read zero by default and normally
// - Defined condition sets its flag to one
// - Set flag sticks until host read clears
// - Module reset pin clears all flags
// - Byte 3 low nibble: receive signal loss
// - Byte 3 high nibble: transmit loss, never set
// - Byte 4 low nibble: laser fault per lane
// - Byte 4 high nibble: equaliser fault if supported
// - Byte 5 high nibble: transmit lock loss
// - Byte 5 low nibble: receive lock loss
// - Byte 6 high nibble: temperature alarms, warnings
// - Byte 6 bit 0: initialization complete, read clears
// - Byte 7 high nibble: supply alarms, warnings
// - Byte 2 bit 1 reports interrupt pin level
// - Flags live in always-addressable lower 128 bytes
// - Mask bytes 100-106 writable, 100-104 suppress interrupts
package lsf_pkg;

  // ------------------------------------------------------------
  // Byte offsets
  // ------------------------------------------------------------
  localparam logic [6:0] LSF_STATUS_OFS = 7'h02;
  localparam logic [6:0] LSF_SIGLOSS_OFS = 7'h03;
  localparam logic [6:0] LSF_FAULT_OFS = 7'h04;
  localparam logic [6:0] LSF_LOCKLOSS_OFS = 7'h05;
  localparam logic [6:0] LSF_TEMPINIT_OFS = 7'h06;
  localparam logic [6:0] LSF_SUPPLY_OFS = 7'h07;
  localparam logic [6:0] LSF_VENDOR_OFS = 7'h08;
  localparam logic [6:0] LSF_FLAG_LAST_OFS = 7'h15;
  localparam logic [6:0] LSF_MASK_FIRST_OFS = 7'h64;
  localparam logic [6:0] LSF_MASK_LAST_OFS = 7'h6a;
  localparam int LSF_MASK_BYTES = 7;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int LSF_LANES = 4;
  localparam int LSF_HI_LSB = 4;
  localparam int LSF_INIT_BIT = 0;
  localparam int LSF_INTPIN_BIT = 1;
  localparam int LSF_NOTREADY_BIT = 0;
  localparam int LSF_HI_ALARM_BIT = 3;
  localparam int LSF_LO_ALARM_BIT = 2;
  localparam int LSF_HI_WARN_BIT = 1;
  localparam int LSF_LO_WARN_BIT = 0;

  // ------------------------------------------------------------
  // Reset values and supporting constants
  // ------------------------------------------------------------
  localparam logic [7:0] LSF_FLAG_RST = 8'h00;
  localparam logic [7:0] LSF_MASK_RST = 8'h00;
  localparam logic [7:0] LSF_ZERO_BYTE = 8'h00;
  localparam logic [3:0] LSF_ZERO_NIB = 4'h0;
  localparam logic LSF_EQ_SUPPORTED = 1'b1;
  localparam int LSF_SYNC_STAGES = 3;

endpackage

// [rtl/lsf_sync3.sv]
/*
  Three-stage synchroniser with agreement filter for a bus of pin inputs.
  Assumes inputs asynchronous to clk; output changes once stages 2 and 3 agree.
*/
`timescale 1ns/1ns
`default_nettype none
module lsf_sync3 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // ------------------------------------------------------------
  // Agreement filter
  // ------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          dout[i] <= 1'b0;
        end else if (s2_r[i] == s3_r[i]) begin
          dout[i] <= s3_r[i];
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// [rtl/lsf_flag_bank.sv]
/*
  Latched status flag bank: sticky event flags in bytes 3 to 7, status byte 2,
  interrupt mask bytes and a clear-on-read host read port.
  Assumes a two-wire serial front end on clk that issues one-cycle read and
  write strobes with a lower-page byte address; condition inputs come from pins.
*/
`timescale 1ns/1ns
`default_nettype none
module lsf_flag_bank
  import lsf_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic module_reset_n,
  input wire logic [3:0] rxSignalAbsent,
  input wire logic [3:0] txLaserFault,
  input wire logic [3:0] txEqualiserFault,
  input wire logic [3:0] txClockRecoveryUnlocked,
  input wire logic [3:0] rxClockRecoveryUnlocked,
  input wire logic [3:0] tempAlarmWarn,
  input wire logic [3:0] supplyAlarmWarn,
  input wire logic initDone,
  input wire logic dataNotReady,
  input wire logic hostRd,
  input wire logic hostWr,
  input wire logic [6:0] hostAddr,
  input wire logic [7:0] hostWrData,
  output logic [7:0] hostRdData,
  output logic hostRdValid,
  output logic interrupt_out_n
);

  // ------------------------------------------------------------
  // Decoding helpers
  // ------------------------------------------------------------
  function automatic logic isMaskAddr(input logic [6:0] a);
    isMaskAddr = (a >= LSF_MASK_FIRST_OFS) && (a <= LSF_MASK_LAST_OFS);
  endfunction

  function automatic logic rdHits(input logic rd, input logic [6:0] a,
                                  input logic [6:0] ofs);
    rdHits = rd && (a == ofs);
  endfunction

  // ------------------------------------------------------------
  // Input synchronisation
  // ------------------------------------------------------------
  localparam int NIN = 30;
  logic [NIN-1:0] rawIn;
  logic [NIN-1:0] syncIn;

  assign rawIn = {dataNotReady, initDone, supplyAlarmWarn, tempAlarmWarn,
                  rxClockRecoveryUnlocked, txClockRecoveryUnlocked,
                  txEqualiserFault, txLaserFault, rxSignalAbsent};

  lsf_sync3 #(.W(NIN)) u_sync (
    .clk(clk),
    .rst(rst),
    .din(rawIn),
    .dout(syncIn)
  );

  // Synchronised as active high so it idles inactive after rst
  logic [0:0] resetPinRaw;
  logic [0:0] resetPinSync;
  assign resetPinRaw = ~module_reset_n;
  lsf_sync3 #(.W(1)) u_rsync (
    .clk(clk),
    .rst(rst),
    .din(resetPinRaw),
    .dout(resetPinSync)
  );

  logic pinResetActive;
  assign pinResetActive = resetPinSync[0];

  // ------------------------------------------------------------
  // Event sources, one nibble each, init and not-ready one bit each
  // ------------------------------------------------------------
  logic [3:0] rxAbsent;
  logic [3:0] txFlt;
  logic [3:0] txEq;
  logic [3:0] txUnlocked;
  logic [3:0] rxUnlocked;
  logic [3:0] tempEv;
  logic [3:0] vccEv;
  logic initEv;
  logic notReady;

  assign rxAbsent = syncIn[3:0];
  assign txFlt = syncIn[7:4];
  assign txEq = syncIn[11:8] & {LSF_LANES{LSF_EQ_SUPPORTED}};
  assign txUnlocked = syncIn[15:12];
  assign rxUnlocked = syncIn[19:16];
  assign tempEv = syncIn[23:20];
  assign vccEv = syncIn[27:24];
  assign notReady = syncIn[29];

  // Initialization complete is an edge of the done level
  logic initSeen_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      initSeen_r <= 1'b0;
    end else if (pinResetActive) begin
      initSeen_r <= 1'b0;
    end else begin
      initSeen_r <= syncIn[28];
    end
  end
  assign initEv = syncIn[28] & ~initSeen_r;

  // ------------------------------------------------------------
  // Sticky flag bytes
  // ------------------------------------------------------------
  logic [7:0] sigLoss_r;
  logic [7:0] fault_r;
  logic [7:0] lockLoss_r;
  logic [7:0] tempInit_r;
  logic [7:0] supply_r;
  logic [7:0] sigLoss_nxt;
  logic [7:0] fault_nxt;
  logic [7:0] lockLoss_nxt;
  logic [7:0] tempInit_nxt;
  logic [7:0] supply_nxt;
  logic [7:0] sigLossSet;
  logic [7:0] faultSet;
  logic [7:0] lockLossSet;
  logic [7:0] tempInitSet;
  logic [7:0] supplySet;

  assign sigLossSet = {LSF_ZERO_NIB, rxAbsent};
  assign faultSet = {txEq, txFlt};
  assign lockLossSet = {txUnlocked, rxUnlocked};
  assign tempInitSet = {tempEv, 3'b000, initEv};
  assign supplySet = {vccEv, LSF_ZERO_NIB};

  // Read clears the returned bits, a same-cycle set wins
  always_comb begin
    sigLoss_nxt = sigLoss_r;
    fault_nxt = fault_r;
    lockLoss_nxt = lockLoss_r;
    tempInit_nxt = tempInit_r;
    supply_nxt = supply_r;
    if (rdHits(hostRd, hostAddr, LSF_SIGLOSS_OFS)) begin
      sigLoss_nxt = LSF_FLAG_RST;
    end
    if (rdHits(hostRd, hostAddr, LSF_FAULT_OFS)) begin
      fault_nxt = LSF_FLAG_RST;
    end
    if (rdHits(hostRd, hostAddr, LSF_LOCKLOSS_OFS)) begin
      lockLoss_nxt = LSF_FLAG_RST;
    end
    if (rdHits(hostRd, hostAddr, LSF_TEMPINIT_OFS)) begin
      tempInit_nxt = LSF_FLAG_RST;
    end
    if (rdHits(hostRd, hostAddr, LSF_SUPPLY_OFS)) begin
      supply_nxt = LSF_FLAG_RST;
    end
    sigLoss_nxt = sigLoss_nxt | sigLossSet;
    fault_nxt = fault_nxt | faultSet;
    lockLoss_nxt = lockLoss_nxt | lockLossSet;
    tempInit_nxt = tempInit_nxt | tempInitSet;
    supply_nxt = supply_nxt | supplySet;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sigLoss_r <= LSF_FLAG_RST;
      fault_r <= LSF_FLAG_RST;
      lockLoss_r <= LSF_FLAG_RST;
      tempInit_r <= LSF_FLAG_RST;
      supply_r <= LSF_FLAG_RST;
    end else if (pinResetActive) begin
      sigLoss_r <= LSF_FLAG_RST;
      fault_r <= LSF_FLAG_RST;
      lockLoss_r <= LSF_FLAG_RST;
      tempInit_r <= LSF_FLAG_RST;
      supply_r <= LSF_FLAG_RST;
    end else begin
      sigLoss_r <= sigLoss_nxt;
      fault_r <= fault_nxt;
      lockLoss_r <= lockLoss_nxt;
      tempInit_r <= tempInit_nxt;
      supply_r <= supply_nxt;
    end
  end

  // ------------------------------------------------------------
  // Mask bytes
  // ------------------------------------------------------------
  logic [7:0] mask_r [LSF_MASK_BYTES];
  logic [2:0] maskIdx;
  assign maskIdx = 3'(hostAddr - LSF_MASK_FIRST_OFS);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < LSF_MASK_BYTES; i++) begin
        mask_r[i] <= LSF_MASK_RST;
      end
    end else if (hostWr && isMaskAddr(hostAddr)) begin
      mask_r[maskIdx] <= hostWrData;
    end
  end

  // ------------------------------------------------------------
  // Interrupt pin
  // ------------------------------------------------------------
  logic anyUnmasked;
  assign anyUnmasked = |(sigLoss_r & ~mask_r[0]) | |(fault_r & ~mask_r[1]) |
                       |(lockLoss_r & ~mask_r[2]) | |(tempInit_r & ~mask_r[3]) |
                       |(supply_r & ~mask_r[4]);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      interrupt_out_n <= 1'b1;
    end else begin
      interrupt_out_n <= ~anyUnmasked;
    end
  end

  // ------------------------------------------------------------
  // Host read port, lower page only
  // ------------------------------------------------------------
  logic [7:0] rdMux;
  always_comb begin
    rdMux = LSF_ZERO_BYTE;
    if (isMaskAddr(hostAddr)) begin
      rdMux = mask_r[maskIdx];
    end else begin
      case (hostAddr)
        LSF_STATUS_OFS: begin
          rdMux = LSF_ZERO_BYTE;
          rdMux[LSF_INTPIN_BIT] = interrupt_out_n;
          rdMux[LSF_NOTREADY_BIT] = notReady;
        end
        LSF_SIGLOSS_OFS: rdMux = sigLoss_r;
        LSF_FAULT_OFS: rdMux = fault_r;
        LSF_LOCKLOSS_OFS: rdMux = lockLoss_r;
        LSF_TEMPINIT_OFS: rdMux = tempInit_r;
        LSF_SUPPLY_OFS: rdMux = supply_r;
        LSF_VENDOR_OFS: rdMux = LSF_ZERO_BYTE;
        default: rdMux = LSF_ZERO_BYTE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hostRdData <= LSF_ZERO_BYTE;
      hostRdValid <= 1'b0;
    end else begin
      hostRdValid <= hostRd;
      if (hostRd) begin
        hostRdData <= rdMux;
      end
    end
  end

endmodule
`default_nettype wire

// [tb/lsf_flag_bank_props.sv]
/*
  Checker for the flag bank host read port.
  Assumes a bind onto lsf_flag_bank and a single clock domain.
*/
`timescale 1ns/1ns
`default_nettype none
module lsf_flag_bank_props
  import lsf_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic hostRd,
  input wire logic [6:0] hostAddr,
  input wire logic [7:0] hostRdData,
  input wire logic hostRdValid,
  input wire logic interrupt_out_n
);
  // --------------------------------------------------
  // Properties
  // --------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  chk_rd_gives_valid: assert property (hostRd |=> hostRdValid)
    else $error("read strobe gave no valid pulse");
  chk_valid_needs_rd: assert property (hostRdValid |-> $past(hostRd))
    else $error("valid pulse without read strobe");
  chk_data_held: assert property (!hostRdValid |-> $stable(hostRdData))
    else $error("read data moved without a read");
  chk_tx_loss_zero: assert property (
    hostRd && hostAddr == LSF_SIGLOSS_OFS |=> hostRdData[7:4] == 4'h0)
    else $error("transmit loss bits set");
  chk_temp_rsvd_zero: assert property (
    hostRd && hostAddr == LSF_TEMPINIT_OFS |=> hostRdData[3:1] == 3'h0)
    else $error("reserved temperature bits set");
  chk_supply_rsvd_zero: assert property (
    hostRd && hostAddr == LSF_SUPPLY_OFS |=> hostRdData[3:0] == 4'h0)
    else $error("reserved supply bits set");
  chk_vendor_byte_zero: assert property (
    hostRd && hostAddr == LSF_VENDOR_OFS |=> hostRdData == 8'h00)
    else $error("vendor byte not zero");
  chk_status_upper_zero: assert property (
    hostRd && hostAddr == LSF_STATUS_OFS |=> hostRdData[7:2] == 6'h00)
    else $error("status upper bits set");
  chk_int_reset_high: assert property ($fell(rst) |-> interrupt_out_n)
    else $error("interrupt low after reset");
  cover property (hostRd && hostAddr == LSF_SIGLOSS_OFS);
  cover property ($fell(interrupt_out_n));
  cover property (hostRd ##1 hostRdValid && hostRdData != 8'h00);
endmodule
`default_nettype wire

// [tb/lsf_host_model.sv]
/*
  Host controller model issuing one-byte reads and writes.
  Assumes the read answer arrives one cycle after the strobe.
*/
`timescale 1ns/1ns
`default_nettype none
module lsf_host_model
  import lsf_pkg::*;
(
  input wire logic clk,
  output logic hostRd,
  output logic hostWr,
  output logic [6:0] hostAddr,
  output logic [7:0] hostWrData,
  input wire logic [7:0] hostRdData,
  input wire logic hostRdValid
);
  // --------------------------------------------------
  // Bus tasks
  // --------------------------------------------------
  initial begin
    hostRd = 1'b0;
    hostWr = 1'b0;
    hostAddr = 7'h7f;
    hostWrData = 8'h00;
  end
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    d = 8'hxx;
    @(posedge clk);
    #1 hostRd = 1'b1;
    hostAddr = a;
    @(posedge clk);
    #1 hostRd = 1'b0;
    hostAddr = ~a;
    if (hostRdValid === 1'b1) d = hostRdData;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    @(posedge clk);
    #1 hostWr = 1'b1;
    hostAddr = a;
    hostWrData = v;
    @(posedge clk);
    #1 hostWr = 1'b0;
    hostAddr = ~a;
    hostWrData = ~v;
  endtask
endmodule
`default_nettype wire

// [tb/testbench.sv]
/*
  Self-checking bench for the latched status flag bank.
  Assumes lsf_host_model as host and condition pins driven here.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module testbench
  import lsf_pkg::*;
;
  // --------------------------------------------------
  // Bench
  // --------------------------------------------------
  logic clk = 0, rst = 1, module_reset_n = 1, initDone = 0, dataNotReady = 1;
  logic hostRd, hostWr, hostRdValid, interrupt_out_n;
  logic [3:0] cond [7];
  logic [6:0] hostAddr;
  logic [7:0] hostWrData, hostRdData, d;
  int miscompares = 0, total_checks = 0;
  int addrTab[7] = '{3, 4, 4, 5, 5, 6, 7};
  int shTab[7] = '{0, 0, 4, 4, 0, 4, 4};
  always #5 clk = ~clk;
  lsf_flag_bank dut_u (.clk(clk), .rst(rst), .module_reset_n(module_reset_n),
    .rxSignalAbsent(cond[0]), .txLaserFault(cond[1]), .txEqualiserFault(cond[2]),
    .txClockRecoveryUnlocked(cond[3]), .rxClockRecoveryUnlocked(cond[4]),
    .tempAlarmWarn(cond[5]), .supplyAlarmWarn(cond[6]), .initDone(initDone),
    .dataNotReady(dataNotReady), .hostRd(hostRd), .hostWr(hostWr), .hostAddr(hostAddr),
    .hostWrData(hostWrData), .hostRdData(hostRdData), .hostRdValid(hostRdValid),
    .interrupt_out_n(interrupt_out_n));
  lsf_host_model host_u (.clk(clk), .hostRd(hostRd), .hostWr(hostWr),
    .hostAddr(hostAddr), .hostWrData(hostWrData), .hostRdData(hostRdData),
    .hostRdValid(hostRdValid));
  task wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task give_verdict;
    $display("checks=%0d mismatches=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    give_verdict();
  end
  initial begin
    foreach (cond[i]) cond[i] = 4'h0;
    repeat (20) @(posedge clk);
    #1 rst = 0;
    wt(8);
    for (int a = 2; a <= 8; a++) begin
      host_u.rd(7'(a), d);
      `CHK(d, (a == 2) ? 8'h03 : 8'h00)
    end
    $display("test idle done");
    for (int g = 0; g < 7; g++) begin
      cond[g] = 4'hb;
      wt(8);
      cond[g] = 4'h0;
      wt(8);
      `CHK(interrupt_out_n, 1'b0)
      host_u.rd(7'(addrTab[g]), d);
      `CHK(d, 8'(8'h0b << shTab[g]))
      host_u.rd(7'(addrTab[g]), d);
      `CHK(d, 8'h00)
    end
    wt(2);
    `CHK(interrupt_out_n, 1'b1)
    $display("test groups done");
    host_u.wr(LSF_MASK_FIRST_OFS, 8'h0f);
    host_u.rd(LSF_MASK_FIRST_OFS, d);
    `CHK(d, 8'h0f)
    host_u.wr(LSF_MASK_LAST_OFS, 8'ha5);
    host_u.rd(LSF_MASK_LAST_OFS, d);
    `CHK(d, 8'ha5)
    host_u.wr(LSF_SIGLOSS_OFS, 8'hff);
    cond[0] = 4'h1;
    wt(8);
    cond[0] = 4'h0;
    wt(2);
    `CHK(interrupt_out_n, 1'b1)
    host_u.rd(LSF_SIGLOSS_OFS, d);
    `CHK(d, 8'h01)
    host_u.wr(LSF_MASK_FIRST_OFS, 8'h00);
    $display("test mask done");
    cond[0] = 4'h4;
    wt(8);
    host_u.rd(LSF_SIGLOSS_OFS, d);
    host_u.rd(LSF_SIGLOSS_OFS, d);
    `CHK(d, 8'h04)
    cond[0] = 4'h0;
    wt(8);
    host_u.rd(LSF_SIGLOSS_OFS, d);
    `CHK(d, 8'h04)
    host_u.rd(LSF_SIGLOSS_OFS, d);
    `CHK(d, 8'h00)
    $display("test set wins done");
    initDone = 1;
    dataNotReady = 0;
    wt(8);
    host_u.rd(LSF_TEMPINIT_OFS, d);
    `CHK(d, 8'h01)
    host_u.rd(LSF_TEMPINIT_OFS, d);
    `CHK(d, 8'h00)
    host_u.rd(LSF_STATUS_OFS, d);
    `CHK(d, 8'h02)
    $display("test init done");
    cond[6] = 4'h8;
    wt(8);
    cond[6] = 4'h0;
    module_reset_n = 0;
    wt(8);
    `CHK(interrupt_out_n, 1'b1)
    module_reset_n = 1;
    wt(8);
    host_u.rd(LSF_SUPPLY_OFS, d);
    `CHK(d, 8'h00)
    host_u.rd(LSF_TEMPINIT_OFS, d);
    `CHK(d, 8'h01)
    $display("test reset pin done");
    give_verdict();
  end
endmodule
bind lsf_flag_bank lsf_flag_bank_props chk_u (.clk(clk), .rst(rst), .hostRd(hostRd),
  .hostAddr(hostAddr), .hostRdData(hostRdData), .hostRdValid(hostRdValid),
  .interrupt_out_n(interrupt_out_n));
`default_nettype wire
